// ---- pkg/serdes_rx_pkg.sv ----
// Shared constants, field layouts and types of the receiver channel control block
package serdes_rx_pkg;

    // Clock rate and documented or chosen times
    localparam int CLK_PERIOD_NS   = 8;
    localparam int LOCK_TIME_NS    = 4000;
    localparam int DETECT_TIME_NS  = 1000;
    localparam int POWER_SETTLE_NS = 200;

    // Least times round up to whole cycles
    localparam logic [15:0] LOCK_CYCLES   =
        16'((LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] DETECT_CYCLES =
        16'((DETECT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] POWER_CYCLES  =
        16'((POWER_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Register byte addresses
    localparam logic [3:0] CONFIG_ADDR = 4'h0;
    localparam logic [3:0] STATUS_ADDR = 4'h4;

    // Word aligner and phase-compensation FIFO
    localparam logic [3:0] SLIP_MAX   = 4'h9;
    localparam logic [2:0] FIFO_DEPTH = 3'h4;
    localparam logic [2:0] FIFO_RESET_LEVEL = 3'h2;

    // Two-stage synchroniser depth for asynchronous controls
    localparam int SYNC_STAGES = 2;

    typedef enum logic [1:0] {
        LOCK_AUTO = 2'b00,
        LOCK_REF  = 2'b01,
        LOCK_DATA = 2'b10
    } lock_mode_type;

    typedef enum logic {
        CDR_REF  = 1'b0,
        CDR_DATA = 1'b1
    } cdr_state_type;

    typedef enum logic [1:0] {
        POWER_P0  = 2'b00,
        POWER_P0S = 2'b01,
        POWER_P1  = 2'b10,
        POWER_P2  = 2'b11
    } power_type;

    typedef enum logic [1:0] {
        PHY_IDLE   = 2'b00,
        PHY_DETECT = 2'b01,
        PHY_POWER  = 2'b10
    } phy_state_type;

    // Software configuration, low bits of the config word
    typedef struct packed {
        logic [3:0] threshold;
        logic       readClkEnable;
        logic       manualAlign;
        logic       gigabitEthernetConfig;
        logic       pipeMode;
        logic       use8b10b;
    } config_type;

    localparam config_type CONFIG_RESET = 9'h100;

    // Channel state shown in the status word
    typedef struct packed {
        logic [3:0] alignerSlipCount;
        power_type  powerState;
        logic       receiverFound;
        logic       reverseLoopback;
        logic       signalDetect;
        logic       fifoError;
        logic       lockedToData;
    } status_type;

    // Asynchronous controls from the PIPE MAC or fabric
    typedef struct packed {
        logic       forceDataLock;
        logic       forceRefLock;
        logic       detectLoop;
        logic       forceElecIdle;
        logic       complianceDisparityForce;
        logic       decoderPolarityInvert;
        logic [1:0] powerDown;
    } pipe_ctrl_type;

    localparam int PIPE_CTRL_WIDTH = 8;

endpackage

// ---- verification/pipe_mac_model.sv ----
// Behavioural PIPE MAC driving the channel's asynchronous controls
`timescale 1ns/1ps
module pipe_mac_model
    import serdes_rx_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       phyDone,
    input  wire logic       detectReq,
    input  wire logic       loopReq,
    input  wire logic [1:0] lockPair,
    input  wire logic       elecIdle,
    input  wire logic       polInv,
    input  wire logic       complianceReq,
    input  wire logic [1:0] powerReq,
    output pipe_ctrl_type   pipeCtrl
);
    logic detecting;
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            detecting <= 1'b0;
        end else if (detectReq) begin
            detecting <= 1'b1;
        end else if (phyDone) begin
            detecting <= 1'b0;
        end
    end
    // Compliance force is a one-cycle request, first byte only
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pipeCtrl <= '0;
        end else begin
            pipeCtrl <= '{lockPair[1], lockPair[0], detecting | loopReq, elecIdle,
                complianceReq, polInv, powerReq};
        end
    end
endmodule // pipe_mac_model

// ---- verification/serdes_rx_monitor.sv ----
// Port checks for the receiver channel control block
`timescale 1ns/1ps
module serdes_rx_monitor
    import serdes_rx_pkg::*;
(
    input wire logic          clk,
    input wire logic          reset_n,
    input wire pipe_ctrl_type pipeCtrl,
    input wire logic          fifoWrite,
    input wire logic          fifoRead,
    input wire logic [9:0]    codeGroup,
    input wire logic          fifoError,
    input wire logic [3:0]    alignerSlipCount,
    input wire logic          lockedToData,
    input wire logic          reverseLoopback,
    input wire logic          encoderNegDisparity,
    input wire logic [9:0]    decoderIn,
    input wire logic          phyDone,
    input wire logic          receiverFound,
    input wire power_type     powerState
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic [2:0] level;
    // Bench never overfills, so no saturation here
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            level <= FIFO_RESET_LEVEL;
        end else if (fifoWrite && !fifoRead) begin
            level <= level + 3'h1;
        end else if (fifoRead && !fifoWrite) begin
            level <= level - 3'h1;
        end
    end
    sequence s_forceData;
        pipeCtrl.forceDataLock [*4];
    endsequence
    sequence s_pulse;
        phyDone ##1 !phyDone;
    endsequence
    AST_LOCK_DATA: assert property (s_forceData |=> lockedToData)
        else $error("data lock not taken");
    AST_LOCK_REF: assert property ((!pipeCtrl.forceDataLock && pipeCtrl.forceRefLock) [*4]
        |=> !lockedToData) else $error("reference lock not taken");
    AST_FIFO_ERR: assert property (fifoError == (level == 3'h0 || level == FIFO_DEPTH))
        else $error("fifo flag wrong");
    AST_SLIP_RANGE: assert property (alignerSlipCount <= SLIP_MAX)
        else $error("slip count out of range");
    AST_DONE_PULSE: assert property (phyDone |-> s_pulse)
        else $error("done longer than one cycle");
    AST_LOOPBACK: assert property (reverseLoopback |-> $past(powerState) == POWER_P0)
        else $error("loopback outside P0");
    AST_FOUND: assert property ($changed(receiverFound) |-> phyDone)
        else $error("detect result without done");
    AST_POWER: assert property ($changed(powerState) |-> phyDone)
        else $error("power change without done");
    AST_POLARITY: assert property (pipeCtrl.decoderPolarityInvert [*4]
        |=> decoderIn == ~$past(codeGroup)) else $error("decoder bits not inverted");
    // Delay first, so the history looked at never reaches before reset
    AST_DISPARITY: assert property (
        ##3 encoderNegDisparity == $past(pipeCtrl.complianceDisparityForce, 3))
        else $error("disparity force wrong");
endmodule // serdes_rx_monitor

// ---- verification/test_serdes_rx_cdr_pipe_control.sv ----
// Self-checking bench for the receiver channel control block
`timescale 1ns/1ps
module test_serdes_rx_cdr_pipe_control;
    import serdes_rx_pkg::*;
    logic          clk, reset_n, avs_read, avs_write, avs_waitrequest, fifoWrite, fifoRead;
    logic          slipRequest, refFreqOk, farEndPresent, rxFifoReadClk, fifoError;
    logic          lockedToData, signalDetect, recoveredClk, reverseLoopback, phyDone;
    logic          encoderNegDisparity, receiverFound, detectReq, loopReq, elecIdle;
    logic          polInv, complianceReq;
    logic [1:0]    lockPair, powerReq;
    logic [3:0]    avs_address, lineAmplitude, alignerSlipCount;
    logic [9:0]    codeGroup, decoderIn;
    logic [31:0]   avs_writedata, avs_readdata, rd;
    pipe_ctrl_type pipeCtrl;
    power_type     powerState;
    int            failures, n_compared, cycles;

    serdes_rx_cdr_pipe_control u_dut (.*);
    pipe_mac_model u_mac (.*);

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        if (failures == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            failures++;
            close_out();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Request held until the rising edge that sees waitrequest low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= d;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wait_done();
        do @(negedge clk); while (phyDone !== 1'b1);
        @(posedge clk);
    endtask

    task automatic t_regs();
        bus(1'b0, CONFIG_ADDR, '0);
        check(rd, 32'(CONFIG_RESET));
        bus(1'b0, 4'h8, '0);
        check(rd, 32'h0);
        bus(1'b1, STATUS_ADDR, 32'hffff_ffff);
        bus(1'b0, STATUS_ADDR, '0);
        check(rd, 32'h0);
        bus(1'b1, CONFIG_ADDR, 32'h0000_0110);
        tick(2);
        @(negedge clk);
        rd[0] = rxFifoReadClk;
        @(negedge clk);
        check(rxFifoReadClk, !rd[0]);
        @(posedge clk);
    endtask

    task automatic t_fifo();
        check(fifoError, 1'b0);
        fifoRead <= 1'b1;
        tick(2);
        fifoRead <= 1'b0;
        tick(2);
        check(fifoError, 1'b1);
        fifoWrite <= 1'b1;
        tick(4);
        fifoWrite <= 1'b0;
        tick(2);
        check(fifoError, 1'b1);
        fifoRead <= 1'b1;
        tick(1);
        fifoRead <= 1'b0;
        tick(2);
        check(fifoError, 1'b0);
    endtask

    task automatic t_slip();
        bus(1'b1, CONFIG_ADDR, 32'h0000_0108);
        for (int i = 1; i <= 10; i++) begin
            slipRequest <= 1'b1;
            tick(1);
            slipRequest <= 1'b0;
            tick(2);
            check(alignerSlipCount, i % 10);
        end
    endtask

    task automatic t_lock();
        logic [1:0] pairs[3] = '{2'b10, 2'b11, 2'b01};
        foreach (pairs[i]) begin
            lockPair <= pairs[i];
            tick(6);
            check(lockedToData, !pairs[i][0] || pairs[i][1]);
        end
        lockPair <= 2'b00;
        refFreqOk <= 1'b1;
        lineAmplitude <= 4'h9;
        bus(1'b1, CONFIG_ADDR, 32'h0000_0102);
        tick(int'(LOCK_CYCLES) + 10);
        check(lockedToData, 1'b1);
        check(signalDetect, 1'b1);
        check(recoveredClk, 1'b0);
        bus(1'b1, CONFIG_ADDR, 32'h0000_0104);
        tick(2);
        check(signalDetect, 1'b0);
        @(negedge clk);
        rd[0] = recoveredClk;
        @(negedge clk);
        check(recoveredClk, !rd[0]);
        @(posedge clk);
        bus(1'b1, CONFIG_ADDR, 32'h0000_0102);
        lineAmplitude <= 4'h8;
        tick(5);
        check(lockedToData, 1'b0);
        check(signalDetect, 1'b0);
    endtask

    task automatic power(input logic [1:0] p);
        powerReq <= p;
        wait_done();
        check(powerState, p);
    endtask

    task automatic t_detect(input logic far);
        elecIdle <= 1'b1;
        farEndPresent <= far;
        tick(6);
        detectReq <= 1'b1;
        tick(1);
        detectReq <= 1'b0;
        wait_done();
        check(receiverFound, far);
        tick(6);
    endtask

    task automatic t_data();
        int hits = 0;
        loopReq <= 1'b1;
        elecIdle <= 1'b0;
        polInv <= 1'b1;
        codeGroup <= 10'h0f3;
        tick(5);
        check(reverseLoopback, 1'b1);
        check(decoderIn, 10'h30c);
        loopReq <= 1'b0;
        polInv <= 1'b0;
        complianceReq <= 1'b1;
        tick(1);
        complianceReq <= 1'b0;
        repeat (8) begin
            @(negedge clk);
            if (encoderNegDisparity === 1'b1) hits++;
        end
        check(hits, 1);
        check(reverseLoopback, 1'b0);
        check(decoderIn, 10'h0f3);
        @(posedge clk);
    endtask

    initial begin
        {reset_n, avs_read, avs_write, fifoWrite, fifoRead, slipRequest} = '0;
        {refFreqOk, farEndPresent, detectReq, loopReq, elecIdle, polInv} = '0;
        {complianceReq, lockPair, powerReq, avs_address, lineAmplitude} = '0;
        {codeGroup, avs_writedata, failures, n_compared, cycles} = '0;
        tick(2);
        reset_n <= 1'b1;
        tick(1);
        t_regs();
        t_fifo();
        t_slip();
        t_lock();
        power(POWER_P0S);
        power(POWER_P2);
        power(POWER_P0);
        power(POWER_P1);
        t_detect(1'b1);
        t_detect(1'b0);
        power(POWER_P0);
        t_data();
        close_out();
    end
endmodule // test_serdes_rx_cdr_pipe_control

bind serdes_rx_cdr_pipe_control serdes_rx_monitor u_mon (.*);

// ---- verilog/serdes_rx_cdr_pipe_control.sv ----
// Receiver channel lock, status and PIPE control logic with Avalon-MM registers
//
// Decided for this implementation: the address map and register access over Avalon-MM.
`timescale 1ns/1ps

// Notes on behaviour
// - Optional FIFO read clock output offered
// - FIFO error high when full or empty
// - FIFO error synchronous to channel clock
// - Manual aligner reports slipped bits 0..9
// - Lock high in data lock, low reference
// - Force-data-lock wins, else reference input rules
// - Lock pair 00 auto, 01 reference, 1x data
// - Signal detect high above programmed threshold
// - Signal detect only basic-8b10b or PIPE
// - Recovered clock only in gigabit Ethernet
// - Detect in P1 with idle forced starts
// - Detect in P0 without idle gives loopback
// - Compliance force makes encoder use negative disparity
// - Polarity invert flips all ten decoder bits
// - Power codes P0, P0s, P1, P2
// - Completion pulses in the same cycle as the transition
module serdes_rx_cdr_pipe_control
    import serdes_rx_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          reset_n,
    input  wire logic [3:0]    avs_address,
    input  wire logic          avs_read,
    input  wire logic          avs_write,
    input  wire logic [31:0]   avs_writedata,
    output logic      [31:0]   avs_readdata,
    output logic               avs_waitrequest,
    input  wire pipe_ctrl_type pipeCtrl,
    input  wire logic          fifoWrite,
    input  wire logic          fifoRead,
    input  wire logic          slipRequest,
    input  wire logic [3:0]    lineAmplitude,
    input  wire logic          refFreqOk,
    input  wire logic          farEndPresent,
    input  wire logic [9:0]    codeGroup,
    output logic               rxFifoReadClk,
    output logic               fifoError,
    output logic      [3:0]    alignerSlipCount,
    output logic               lockedToData,
    output logic               signalDetect,
    output logic               recoveredClk,
    output logic               reverseLoopback,
    output logic               encoderNegDisparity,
    output logic      [9:0]    decoderIn,
    output logic               phyDone,
    output logic               receiverFound,
    output power_type          powerState
);

    config_type    cfg;
    status_type    status;
    pipe_ctrl_type ctrl;
    logic          busAck;
    logic          detectLoopLast;
    logic          detectStart;
    lock_mode_type lockMode;
    cdr_state_type cdrState;
    logic [15:0]   lockTimer;
    logic          signalAbove;
    logic [2:0]    fifoLevel;
    logic [2:0]    next_fifoLevel;
    logic [3:0]    slipCount;
    phy_state_type phyState;
    logic [15:0]   phyTimer;
    power_type     powerTarget;

    // Asynchronous controls enter the channel clock domain
    sync_stage #(
        .WIDTH   (PIPE_CTRL_WIDTH)
    ) ctrlSync (
        .clk     (clk),
        .reset_n (reset_n),
        .asyncIn (pipeCtrl),
        .syncOut (ctrl)
    );

    // Avalon-MM slave: one wait state per access
    assign avs_waitrequest = (avs_read | avs_write) & ~busAck;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            busAck <= 1'b0;
        end else begin
            busAck <= (avs_read | avs_write) & ~busAck;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cfg <= CONFIG_RESET;
        end else if (avs_write && busAck && avs_address == CONFIG_ADDR) begin
            cfg <= avs_writedata[$bits(config_type)-1:0];
        end
    end

    assign status = '{
        alignerSlipCount: alignerSlipCount,
        powerState:       powerState,
        receiverFound:    receiverFound,
        reverseLoopback:  reverseLoopback,
        signalDetect:     signalDetect,
        fifoError:        fifoError,
        lockedToData:     lockedToData
    };

    // Read data loaded on the same edge at which waitrequest drops
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !busAck) begin
            case (avs_address)
                CONFIG_ADDR: begin
                    avs_readdata <= {{(32 - $bits(config_type)){1'b0}}, cfg};
                end
                STATUS_ADDR: begin
                    avs_readdata <= {{(32 - $bits(status_type)){1'b0}}, status};
                end
                default: begin
                    avs_readdata <= 32'h0000_0000;
                end
            endcase
        end
    end

    // Lock mode from the force pair; data lock dominates
    always_comb begin
        if (ctrl.forceDataLock) begin
            lockMode = LOCK_DATA;
        end else if (ctrl.forceRefLock) begin
            lockMode = LOCK_REF;
        end else begin
            lockMode = LOCK_AUTO;
        end
    end

    assign signalAbove = lineAmplitude > cfg.threshold;

    // Automatic mode waits out the lock time before trusting data
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cdrState  <= CDR_REF;
            lockTimer <= 16'h0000;
        end else begin
            case (lockMode)
                LOCK_DATA: begin
                    cdrState  <= CDR_DATA;
                    lockTimer <= 16'h0000;
                end
                LOCK_REF: begin
                    cdrState  <= CDR_REF;
                    lockTimer <= 16'h0000;
                end
                LOCK_AUTO: begin
                    if (cdrState == CDR_DATA) begin
                        if (!signalAbove) begin
                            cdrState <= CDR_REF;
                        end
                        lockTimer <= 16'h0000;
                    end else if (refFreqOk && signalAbove) begin
                        if (lockTimer >= LOCK_CYCLES - 16'h0001) begin
                            cdrState  <= CDR_DATA;
                            lockTimer <= 16'h0000;
                        end else begin
                            lockTimer <= lockTimer + 16'h0001;
                        end
                    end else begin
                        lockTimer <= 16'h0000;
                    end
                end
                default: begin
                    cdrState  <= CDR_REF;
                    lockTimer <= 16'h0000;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            lockedToData <= 1'b0;
        end else begin
            lockedToData <= (cdrState == CDR_DATA);
        end
    end

    // Detect output hidden in modes that do not carry it
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            signalDetect <= 1'b0;
        end else begin
            signalDetect <= signalAbove
                          & ((cfg.use8b10b & ~cfg.pipeMode & ~cfg.gigabitEthernetConfig)
                          | cfg.pipeMode);
        end
    end

    // Divided clock stands in for the recovered and read clocks
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            recoveredClk <= 1'b0;
        end else if (cfg.gigabitEthernetConfig && cdrState == CDR_DATA) begin
            recoveredClk <= ~recoveredClk;
        end else begin
            recoveredClk <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rxFifoReadClk <= 1'b0;
        end else if (cfg.readClkEnable) begin
            rxFifoReadClk <= ~rxFifoReadClk;
        end else begin
            rxFifoReadClk <= 1'b0;
        end
    end

    // Phase-compensation FIFO fill level; overflow and underflow are refused
    always_comb begin
        next_fifoLevel = fifoLevel;
        if (fifoWrite && !fifoRead && fifoLevel != FIFO_DEPTH) begin
            next_fifoLevel = fifoLevel + 3'h1;
        end else if (fifoRead && !fifoWrite && fifoLevel != 3'h0) begin
            next_fifoLevel = fifoLevel - 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            fifoLevel <= FIFO_RESET_LEVEL;
            fifoError <= 1'b0;
        end else begin
            fifoLevel <= next_fifoLevel;
            fifoError <= (next_fifoLevel == FIFO_DEPTH)
                       | (next_fifoLevel == 3'h0);
        end
    end

    // Slip counter wraps after nine; reads zero outside manual alignment
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            slipCount <= 4'h0;
        end else if (!cfg.manualAlign) begin
            slipCount <= 4'h0;
        end else if (slipRequest) begin
            slipCount <= (slipCount == SLIP_MAX) ? 4'h0 : slipCount + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            alignerSlipCount <= 4'h0;
        end else begin
            alignerSlipCount <= cfg.manualAlign ? slipCount : 4'h0;
        end
    end

    // Encoder disparity force and decoder inversion, registered
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            encoderNegDisparity <= 1'b0;
        end else begin
            encoderNegDisparity <= ctrl.complianceDisparityForce;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            decoderIn <= 10'h000;
        end else begin
            decoderIn <= ctrl.decoderPolarityInvert ? ~codeGroup : codeGroup;
        end
    end

    // A held detect level starts only one detection
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            detectLoopLast <= 1'b0;
        end else begin
            detectLoopLast <= ctrl.detectLoop;
        end
    end

    assign detectStart = ctrl.detectLoop & ~detectLoopLast
                       & (powerState == POWER_P1) & ctrl.forceElecIdle;

    // PHY sequencer: detection first, then power changes
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            phyState      <= PHY_IDLE;
            phyTimer      <= 16'h0000;
            powerTarget   <= POWER_P0;
            powerState    <= POWER_P0;
            receiverFound <= 1'b0;
            phyDone       <= 1'b0;
        end else begin
            phyDone <= 1'b0;
            case (phyState)
                PHY_IDLE: begin
                    phyTimer <= 16'h0000;
                    if (cfg.pipeMode && detectStart) begin
                        phyState <= PHY_DETECT;
                    end else if (ctrl.powerDown != powerState) begin
                        powerTarget <= power_type'(ctrl.powerDown);
                        phyState    <= PHY_POWER;
                    end
                end
                PHY_DETECT: begin
                    if (phyTimer >= DETECT_CYCLES - 16'h0001) begin
                        receiverFound <= farEndPresent;
                        phyDone       <= 1'b1;
                        phyState      <= PHY_IDLE;
                    end else begin
                        phyTimer <= phyTimer + 16'h0001;
                    end
                end
                PHY_POWER: begin
                    if (phyTimer >= POWER_CYCLES - 16'h0001) begin
                        powerState <= powerTarget;
                        phyDone    <= 1'b1;
                        phyState   <= PHY_IDLE;
                    end else begin
                        phyTimer <= phyTimer + 16'h0001;
                    end
                end
                default: begin
                    phyState <= PHY_IDLE;
                end
            endcase
        end
    end

    // Loopback follows the level, so dropping detect leaves it at once
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            reverseLoopback <= 1'b0;
        end else begin
            reverseLoopback <= cfg.pipeMode & ctrl.detectLoop
                             & (powerState == POWER_P0) & ~ctrl.forceElecIdle;
        end
    end

endmodule // serdes_rx_cdr_pipe_control

// ---- verilog/sync_stage.sv ----
// Two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module sync_stage #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] firstStage;

    // First stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            firstStage <= '0;
            syncOut    <= '0;
        end else begin
            firstStage <= asyncIn;
            syncOut    <= firstStage;
        end
    end

endmodule // sync_stage
